//--- shared/pnpi_cfg.svh
// Constants for the plug and play card isolation block
`ifndef PNPI_CFG_SVH
`define PNPI_CFG_SVH
// Card control register indexes written to the address port
`define PNPI_IDX_RDPORT 8'h00
`define PNPI_IDX_SERIAL 8'h01
`define PNPI_IDX_CFGCTL 8'h02
`define PNPI_IDX_WAKE 8'h03
`define PNPI_IDX_CSN 8'h06
`define PNPI_IDX_VENDCTL 8'hf6
// Bit positions in the control registers
`define PNPI_CTL_WFK_BIT 1
`define PNPI_CTL_CSNCLR_BIT 2
`define PNPI_VEND_CSNCLR_BIT 2
// Isolation drive and sense patterns
`define PNPI_DRIVE_FIRST 8'h55
`define PNPI_DRIVE_SECOND 8'haa
`define PNPI_SENSE_FIRST 2'h1
`define PNPI_SENSE_SECOND 2'h2
// Checksum and identifier geometry
`define PNPI_LFSR_SEED 8'h6a
`define PNPI_ID_BITS 7'h48
`define PNPI_SUM_LAST 7'h3f
`define PNPI_CSN_RESET 8'h00
`define PNPI_KEY_LEN 32
// Vendor unlock sequence, first byte in the low bits
`define PNPI_UNLOCK_KEY 256'h50a143860c193265ca942851a2448913264d9a3469d2a4489123468d1b366dda
`endif

//--- shared/pnpi_pkg.sv
// Types for the plug and play card isolation block
package pnpi_pkg;
  typedef enum logic [1:0] {
    PNPI_WAIT_KEY = 2'b00,
    PNPI_SLEEP = 2'b01,
    PNPI_ISOLATE = 2'b10,
    PNPI_CONFIG = 2'b11
  } pnpi_state_t;
endpackage

//--- rtl/pnpi_key_match.sv
// Matcher for the vendor unlock sequence on address port writes
`timescale 1ns/1ps
`include "pnpi_cfg.svh"
module pnpi_key_match #(
  parameter int KEY_LEN = `PNPI_KEY_LEN
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Address port write
  input wire logic wr_ev,
  input wire logic [7:0] wr_data,
  // Whole sequence seen
  output logic match
);
  localparam logic [255:0] KEY = `PNPI_UNLOCK_KEY;
  logic [5:0] pos_q;
  logic [7:0] expect_b;
  logic [7:0] first_b;

  generate
    if (KEY_LEN != 32) begin : g_chk
      $error("pnpi_key_match serves a 32 byte sequence only");
    end
  endgenerate

  assign expect_b = KEY[{pos_q[4:0], 3'h0} +: 8];
  assign first_b = KEY[7:0];
  assign match = wr_ev && (expect_b == wr_data) && (pos_q == 6'h1f);

  // A wrong byte restarts the match, but may itself open a new attempt
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_q <= 6'h00;
    end else if (wr_ev) begin
      if (match) begin
        pos_q <= 6'h00;
      end else if (expect_b == wr_data) begin
        pos_q <= pos_q + 6'h01;
      end else if (wr_data == first_b) begin
        pos_q <= 6'h01;
      end else begin
        pos_q <= 6'h00;
      end
    end
  end
endmodule

//--- rtl/pnpi_lfsr.sv
// Serial identifier checksum shift register
`timescale 1ns/1ps
`include "pnpi_cfg.svh"
module pnpi_lfsr (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic load,
  input wire logic shift,
  input wire logic serial_bit,
  // State
  output logic [7:0] value,
  output logic [7:0] value_nxt
);
  logic [7:0] lfsr_q;

  assign value = lfsr_q;
  assign value_nxt = {lfsr_q[1] ^ lfsr_q[0] ^ serial_bit, lfsr_q[7:1]};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_q <= `PNPI_LFSR_SEED;
    end else if (load) begin
      lfsr_q <= `PNPI_LFSR_SEED;
    end else if (shift) begin
      lfsr_q <= value_nxt;
    end
  end
endmodule

//--- rtl/pnpi_isolation.sv
// Plug and play card isolation: unlock, card states, serial isolation
// Notes on behaviour
// - Vendor unlock sequence DA, 6D ... 50 is acted on only in Wait for Key.
// - Each address write is matched; mismatch restarts; ports open on full match.
// - Identifier is 72 bits: 32-bit vendor, 32-bit unique, 8-bit checksum.
// - Identifier bits leave least significant first within each byte.
// - One identifier bit per pair of readback reads; 72 pairs per pass.
// - First read drives 55H for a one; a zero floats and senses 01.
// - Second read drives AAH after driving; a floating card senses 10.
// - Floating card sensing both patterns drops out of this pass only.
// - Drive all eight data lines; sense only the lowest two.
// - Driver or undisturbed floater advances to the next identifier bit.
// - Card with nonzero select number skips isolation; others ignore commands.
// - Checksum register loads 6AH on every wake command.
// - After each pair shift right; bit 7 gets bit1 xor bit0 xor data.
// - After 64 pairs the register holds the checksum; last 8 bits use it.
// - Never drive IOCHRDY during serial isolation.
// - Reset-drive clears select number and enters Wait for Key.
// - Wait for Key command from any state; select clears keep the state.
// - Unlock leads to Sleep; wake with 00H enters Isolation and rewinds.
// - Losers go to Sleep; select number write enters Config; wake mismatch sleeps.
`timescale 1ns/1ps
`include "pnpi_cfg.svh"
module pnpi_isolation
  import pnpi_pkg::*;
#(
  parameter logic [31:0] VENDOR_ID = 32'h0000a5c3, // Arbitrary value
  parameter logic [31:0] UNIQUE_ID = 32'h00000001 // Arbitrary value
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // ISA side strobes, decoded outside, asynchronous
  input wire logic ADDR_WR_STB,
  input wire logic WDATA_WR_STB,
  input wire logic RDATA_RD_STB,
  // ISA data bus, split
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  // Ready line; the controller asks for wait states on the same clock
  input wire logic CHRDY_REQ,
  output logic IOCHRDY_OUT,
  output logic IOCHRDY_OE,
  // Status towards the rest of the controller
  output logic [1:0] PNP_STATE,
  output logic [7:0] CARD_SELECT_NUMBER,
  output logic [7:0] RDPORT_ADDR,
  output logic ID_REWIND
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [2:0] aw_q;
  logic [2:0] dw_q;
  logic [2:0] rd_q;
  logic [7:0] din_m_q;
  logic [7:0] din_q;
  logic addr_ev;
  logic wr_ev;
  logic rd_rise;
  logic rd_fall;
  pnpi_state_t state_q;
  pnpi_state_t state_d;
  logic [7:0] index_q;
  logic [7:0] csn_q;
  logic [7:0] rdport_q;
  logic [6:0] idx_q;
  logic second_q;
  logic sense1_q;
  logic drive_q;
  logic [7:0] dout_q;
  logic [7:0] chk_q;
  logic rewind_q;
  logic key_hit;
  logic [63:0] id64;
  logic cur_bit;
  logic serial_sel;
  logic pair_done;
  logic pair_lose;
  logic pair_adv;
  logic wake_ev;
  logic csn_wr;
  logic ctl_wr;
  logic vend_wr;
  logic wfk_cmd;
  logic csn_clr;
  logic [7:0] lfsr_val;
  logic [7:0] lfsr_nxt;

  generate
    if ({UNIQUE_ID, VENDOR_ID} == 64'h0) begin : g_chk
      $error("pnpi_isolation needs a nonzero serial identifier");
    end
  endgenerate

  // Reset release through two flip-flops
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Strobe synchronisers; the third stage only serves edge detection
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_q <= 3'h0;
      dw_q <= 3'h0;
      rd_q <= 3'h0;
    end else begin
      aw_q <= {aw_q[1:0], ADDR_WR_STB};
      dw_q <= {dw_q[1:0], WDATA_WR_STB};
      rd_q <= {rd_q[1:0], RDATA_RD_STB};
    end
  end

  // Data is resynchronised with the same latency as the strobes, so it must
  // stay stable a few clocks past the end of the strobe, as ISA hold gives
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      din_m_q <= 8'h00;
      din_q <= 8'h00;
    end else begin
      din_m_q <= DATA_IN;
      din_q <= din_m_q;
    end
  end

  assign addr_ev = aw_q[2] && !aw_q[1];
  assign wr_ev = dw_q[2] && !dw_q[1] && (state_q != PNPI_WAIT_KEY);
  assign rd_rise = rd_q[1] && !rd_q[2];
  assign rd_fall = rd_q[2] && !rd_q[1];

  pnpi_key_match #(
    .KEY_LEN(`PNPI_KEY_LEN)
  ) u_key (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .wr_ev(addr_ev),
    .wr_data(din_q),
    .match(key_hit)
  );

  // Command decode
  assign wake_ev = wr_ev && (index_q == `PNPI_IDX_WAKE);
  assign csn_wr = wr_ev && (index_q == `PNPI_IDX_CSN) &&
                  ((state_q == PNPI_ISOLATE) || (state_q == PNPI_CONFIG));
  assign ctl_wr = wr_ev && (index_q == `PNPI_IDX_CFGCTL);
  assign vend_wr = wr_ev && (index_q == `PNPI_IDX_VENDCTL);
  assign wfk_cmd = ctl_wr && din_q[`PNPI_CTL_WFK_BIT];
  assign csn_clr = (ctl_wr && din_q[`PNPI_CTL_CSNCLR_BIT]) ||
                   (vend_wr && din_q[`PNPI_VEND_CSNCLR_BIT]);

  // Address port writes select the register once the card is unlocked
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      index_q <= 8'h00;
    end else if (addr_ev && (state_q != PNPI_WAIT_KEY)) begin
      index_q <= din_q;
    end
  end

  // Identifier: vendor field in the low word, so bit 0 leaves first
  assign id64 = {UNIQUE_ID, VENDOR_ID};
  assign cur_bit = (idx_q > `PNPI_SUM_LAST) ? chk_q[idx_q[2:0]] : id64[idx_q[5:0]];

  assign serial_sel = (state_q == PNPI_ISOLATE) && (index_q == `PNPI_IDX_SERIAL);
  assign pair_done = serial_sel && rd_fall && second_q;
  assign pair_lose = pair_done && !drive_q && !cur_bit && sense1_q &&
                     (din_q[1:0] == `PNPI_SENSE_SECOND);
  assign pair_adv = pair_done && !pair_lose && (idx_q < `PNPI_ID_BITS);

  // Next state of a wake: matching number selects, zero number isolates
  function automatic pnpi_state_t wake_target(input logic [7:0] data, input logic [7:0] card_select_number,
                                              input pnpi_state_t miss);
    if (data != card_select_number) begin
      wake_target = miss;
    end else if (card_select_number == `PNPI_CSN_RESET) begin
      wake_target = PNPI_ISOLATE;
    end else begin
      wake_target = PNPI_CONFIG;
    end
  endfunction

  always_comb begin
    state_d = state_q;
    if (wfk_cmd) begin
      state_d = PNPI_WAIT_KEY;
    end else begin
      case (state_q)
        PNPI_WAIT_KEY: begin
          if (key_hit) begin
            state_d = PNPI_SLEEP;
          end
        end
        PNPI_SLEEP: begin
          if (wake_ev) begin
            state_d = wake_target(din_q, csn_q, PNPI_SLEEP);
          end
        end
        PNPI_ISOLATE: begin
          if (csn_wr) begin
            state_d = PNPI_CONFIG;
          end else if (pair_lose) begin
            state_d = PNPI_SLEEP;
          end else if (wake_ev) begin
            state_d = wake_target(din_q, csn_q, PNPI_SLEEP);
          end
        end
        PNPI_CONFIG: begin
          if (wake_ev) begin
            state_d = wake_target(din_q, csn_q, PNPI_SLEEP);
          end
        end
        default: begin
          state_d = PNPI_WAIT_KEY;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PNPI_WAIT_KEY;
    end else begin
      state_q <= state_d;
    end
  end

  // Card select number; a set in the same cycle as a clear wins
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      csn_q <= `PNPI_CSN_RESET;
    end else if (csn_wr) begin
      csn_q <= din_q;
    end else if (csn_clr) begin
      csn_q <= `PNPI_CSN_RESET;
    end
  end

  // Readback port address, taken while isolating
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdport_q <= 8'h00;
    end else if (wr_ev && (state_q == PNPI_ISOLATE) && (index_q == `PNPI_IDX_RDPORT)) begin
      rdport_q <= din_q;
    end
  end

  // Bit pointer and pair phase; every wake rewinds the identifier
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= 7'h00;
      second_q <= 1'b0;
      sense1_q <= 1'b0;
    end else if (wake_ev) begin
      idx_q <= 7'h00;
      second_q <= 1'b0;
      sense1_q <= 1'b0;
    end else if (serial_sel && rd_fall) begin
      if (!second_q) begin
        second_q <= 1'b1;
        sense1_q <= !drive_q && (din_q[1:0] == `PNPI_SENSE_FIRST);
      end else begin
        second_q <= 1'b0;
        sense1_q <= 1'b0;
        if (pair_adv) begin
          idx_q <= idx_q + 7'h01;
        end
      end
    end
  end

  pnpi_lfsr u_lfsr (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .load(wake_ev),
    .shift(pair_adv),
    .serial_bit(cur_bit),
    .value(lfsr_val),
    .value_nxt(lfsr_nxt)
  );

  // The register keeps shifting through the last eight pairs, so the
  // checksum is frozen the moment the 64th pair completes
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      chk_q <= `PNPI_LFSR_SEED;
    end else if (wake_ev) begin
      chk_q <= `PNPI_LFSR_SEED;
    end else if (pair_adv && (idx_q == `PNPI_SUM_LAST)) begin
      chk_q <= lfsr_nxt;
    end
  end

  // Bus drive for each read of a pair
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      drive_q <= 1'b0;
      dout_q <= 8'h00;
    end else if (rd_rise && serial_sel && (idx_q < `PNPI_ID_BITS)) begin
      drive_q <= cur_bit;
      dout_q <= second_q ? `PNPI_DRIVE_SECOND : `PNPI_DRIVE_FIRST;
    end else if (rd_fall) begin
      drive_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rewind_q <= 1'b0;
    end else begin
      rewind_q <= wake_ev;
    end
  end

  assign DATA_OUT = dout_q;
  assign DATA_OE = drive_q && rd_q[1];
  assign IOCHRDY_OUT = 1'b0;
  assign IOCHRDY_OE = CHRDY_REQ && (state_q != PNPI_ISOLATE);
  assign PNP_STATE = state_q;
  assign CARD_SELECT_NUMBER = csn_q;
  assign RDPORT_ADDR = rdport_q;
  assign ID_REWIND = rewind_q;
  // lfsr_val is connected but read nowhere; no port carries it to the rest of the controller
endmodule

//--- sim/pnpi_isolation_sva.sv
// Port assertions for the card isolation block
`timescale 1ns/1ps
module pnpi_isolation_sva
  import pnpi_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // Bus side
  input wire logic ADDR_WR_STB,
  input wire logic WDATA_WR_STB,
  input wire logic RDATA_RD_STB,
  input wire logic [7:0] DATA_IN,
  input wire logic [7:0] DATA_OUT,
  input wire logic DATA_OE,
  // Ready and status
  input wire logic CHRDY_REQ,
  input wire logic IOCHRDY_OUT,
  input wire logic IOCHRDY_OE,
  input wire logic [1:0] PNP_STATE,
  input wire logic [7:0] CARD_SELECT_NUMBER,
  input wire logic [7:0] RDPORT_ADDR,
  input wire logic ID_REWIND
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  a_drive_pattern: assert property (DATA_OE |-> DATA_OUT == 8'h55 || DATA_OUT == 8'haa)
    else $error("driven byte is not a pattern");
  a_drive_isolate: assert property (DATA_OE |-> PNP_STATE == PNPI_ISOLATE)
    else $error("drive outside isolation");
  a_drive_on_read: assert property ($rose(DATA_OE) |-> $past(RDATA_RD_STB, 2))
    else $error("drive without a read");
  a_drive_release: assert property ($fell(RDATA_RD_STB) |-> ##[0:3] !DATA_OE)
    else $error("drive held after read");
  a_no_ready_iso: assert property (PNP_STATE == PNPI_ISOLATE |-> !IOCHRDY_OE)
    else $error("ready driven in isolation");
  a_key_to_sleep: assert property ($past(PNP_STATE) == PNPI_WAIT_KEY && PNP_STATE != PNPI_WAIT_KEY
    |-> PNP_STATE == PNPI_SLEEP) else $error("unlock did not lead to sleep");
  a_config_csn: assert property ($past(PNP_STATE) == PNPI_ISOLATE && PNP_STATE == PNPI_CONFIG
    |-> CARD_SELECT_NUMBER != 8'h00) else $error("config entered without number");
  a_iso_no_csn: assert property ($past(PNP_STATE) == PNPI_SLEEP && PNP_STATE == PNPI_ISOLATE
    |-> CARD_SELECT_NUMBER == 8'h00) else $error("numbered card isolating");
  a_clear_keeps: assert property ($changed(CARD_SELECT_NUMBER) && CARD_SELECT_NUMBER == 8'h00
    |-> $stable(PNP_STATE)) else $error("number clear moved state");
  a_rewind_pulse: assert property (ID_REWIND |=> !ID_REWIND)
    else $error("rewind longer than a cycle");
  a_wait_quiet: assert property (PNP_STATE == PNPI_WAIT_KEY |-> !DATA_OE)
    else $error("drive while locked");
  c_drive: cover property ($rose(DATA_OE));
  c_lose: cover property ($past(PNP_STATE) == PNPI_ISOLATE && PNP_STATE == PNPI_SLEEP);
  c_config: cover property (PNP_STATE == PNPI_CONFIG);
endmodule
bind pnpi_isolation pnpi_isolation_sva pnpi_isolation_sva_i (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .ADDR_WR_STB(ADDR_WR_STB), .WDATA_WR_STB(WDATA_WR_STB),
  .RDATA_RD_STB(RDATA_RD_STB), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
  .CHRDY_REQ(CHRDY_REQ), .IOCHRDY_OUT(IOCHRDY_OUT), .IOCHRDY_OE(IOCHRDY_OE), .PNP_STATE(PNP_STATE),
  .CARD_SELECT_NUMBER(CARD_SELECT_NUMBER), .RDPORT_ADDR(RDPORT_ADDR), .ID_REWIND(ID_REWIND)
);

//--- sim/pnpi_host_model.sv
// Host model: port strobes, ISA data bus and a rival card
`timescale 1ns/1ps
module pnpi_host_model (
  // Clock
  input wire logic clk,
  // Card drive
  input wire logic [7:0] card_data,
  input wire logic card_oe,
  // Strobes and bus level
  output logic addr_stb,
  output logic wdata_stb,
  output logic rd_stb,
  output logic [7:0] bus
);
  logic [7:0] host_val = 8'h00;
  logic [7:0] rival_val = 8'h00;
  logic [7:0] idle_pat = 8'h00;
  logic host_on = 1'b0;
  logic rival_on = 1'b0;
  initial begin
    addr_stb = 1'b0;
    wdata_stb = 1'b0;
    rd_stb = 1'b0;
  end
  // Undriven bus toggles so a stale value never looks like a rival
  always @(posedge clk) idle_pat <= ~idle_pat;
  assign bus = card_oe ? card_data : rival_on ? rival_val : host_on ? host_val : idle_pat;
  task automatic wr(input logic dport, input logic [7:0] v);
    @(posedge clk);
    host_val <= v;
    host_on <= 1'b1;
    addr_stb <= !dport;
    wdata_stb <= dport;
    repeat (4) @(posedge clk);
    addr_stb <= 1'b0;
    wdata_stb <= 1'b0;
    repeat (6) @(posedge clk);
    host_on <= 1'b0;
  endtask
  // Rival holds its byte past the card's sense point
  task automatic rd(input logic rival, input logic [7:0] rv, output logic [7:0] v);
    @(posedge clk);
    rd_stb <= 1'b1;
    rival_on <= rival;
    rival_val <= rv;
    repeat (5) @(posedge clk);
    @(negedge clk);
    v = bus;
    @(posedge clk);
    rd_stb <= 1'b0;
    repeat (6) @(posedge clk);
    rival_on <= 1'b0;
  endtask
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the card isolation block
`timescale 1ns/1ps
module tb_top
  import pnpi_pkg::*;
;
  localparam logic [31:0] VID = 32'h5a3c81c3; // Arbitrary value
  localparam logic [31:0] UID = 32'h0000e217; // Arbitrary value
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic chrdy_req = 1'b1;
  logic addr_stb, wdata_stb, rd_stb, oe, rdy_out, rdy_oe, rewind;
  logic [7:0] bus, dout, card_select_number, rdport;
  logic [1:0] state;
  logic [71:0] id_exp;
  int miscompares = 0;
  int num_checks = 0;
  logic [7:0] key [32] = '{8'hda, 8'h6d, 8'h36, 8'h1b, 8'h8d, 8'h46, 8'h23, 8'h91,
    8'h48, 8'ha4, 8'hd2, 8'h69, 8'h34, 8'h9a, 8'h4d, 8'h26, 8'h13, 8'h89, 8'h44, 8'ha2,
    8'h51, 8'h28, 8'h94, 8'hca, 8'h65, 8'h32, 8'h19, 8'h0c, 8'h86, 8'h43, 8'ha1, 8'h50};
  pnpi_isolation #(.VENDOR_ID(VID), .UNIQUE_ID(UID)) pnpi_isolation_i (
    .REF_CLK(clk), .RST_B(rst_b), .ADDR_WR_STB(addr_stb), .WDATA_WR_STB(wdata_stb),
    .RDATA_RD_STB(rd_stb), .DATA_IN(bus), .DATA_OUT(dout), .DATA_OE(oe), .CHRDY_REQ(chrdy_req),
    .IOCHRDY_OUT(rdy_out), .IOCHRDY_OE(rdy_oe), .PNP_STATE(state), .CARD_SELECT_NUMBER(card_select_number),
    .RDPORT_ADDR(rdport), .ID_REWIND(rewind));
  pnpi_host_model pnpi_host_model_i (.clk(clk), .card_data(dout), .card_oe(oe),
    .addr_stb(addr_stb), .wdata_stb(wdata_stb), .rd_stb(rd_stb), .bus(bus));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_state(input logic [1:0] got, input logic [1:0] exp);
    chk_byte({6'h00, got}, {6'h00, exp});
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic cmd(input logic [7:0] idx, input logic [7:0] val);
    pnpi_host_model_i.wr(1'b0, idx);
    pnpi_host_model_i.wr(1'b1, val);
  endtask
  task automatic unlock();
    for (int i = 0; i < 32; i++)
      pnpi_host_model_i.wr(1'b0, key[i]);
  endtask
  task automatic pair(input logic rival, output logic b);
    logic [7:0] v1, v2;
    pnpi_host_model_i.rd(rival, 8'h55, v1);
    pnpi_host_model_i.rd(rival, 8'haa, v2);
    b = (v1 === 8'h55) && (v2 === 8'haa);
  endtask
  task automatic t_idle();
    chk_state(state, PNPI_WAIT_KEY);
    chk_byte(card_select_number, 8'h00);
    chk_bit(rdy_oe, 1'b1);
    chk_bit(rdy_out, 1'b0);
    cmd(8'h03, 8'h00);
    chk_state(state, PNPI_WAIT_KEY);
    $display("t_idle done");
  endtask
  task automatic t_unlock();
    for (int i = 0; i < 32; i++) begin
      if (i == 3)
        pnpi_host_model_i.wr(1'b0, 8'h00);
      pnpi_host_model_i.wr(1'b0, key[i]);
    end
    chk_state(state, PNPI_WAIT_KEY);
    unlock();
    chk_state(state, PNPI_SLEEP);
    $display("t_unlock done");
  endtask
  task automatic t_pass();
    logic b;
    cmd(8'h03, 8'h00);
    chk_state(state, PNPI_ISOLATE);
    cmd(8'h00, 8'h80);
    chk_byte(rdport, 8'h80);
    chk_bit(rdy_oe, 1'b0);
    pnpi_host_model_i.wr(1'b0, 8'h01);
    for (int i = 0; i < 72; i++) begin
      pair(1'b0, b);
      chk_bit(b, id_exp[i]);
    end
    chk_state(state, PNPI_ISOLATE);
    $display("t_pass done");
  endtask
  task automatic t_lose();
    logic b;
    cmd(8'h03, 8'h00);
    pnpi_host_model_i.wr(1'b0, 8'h01);
    // Identifier bit 2 is zero, so the rival wins that pair
    for (int i = 0; i < 3; i++) begin
      pair(i == 2, b);
      chk_bit(b, i < 2 ? id_exp[i] : 1'b1);
    end
    chk_state(state, PNPI_SLEEP);
    cmd(8'h03, 8'h00);
    chk_state(state, PNPI_ISOLATE);
    cmd(8'h00, 8'h81);
    chk_byte(rdport, 8'h81);
    pnpi_host_model_i.wr(1'b0, 8'h01);
    pair(1'b0, b);
    chk_bit(b, id_exp[0]);
    $display("t_lose done");
  endtask
  task automatic t_assign();
    cmd(8'h06, 8'h05);
    chk_state(state, PNPI_CONFIG);
    chk_byte(card_select_number, 8'h05);
    cmd(8'h03, 8'h00);
    chk_state(state, PNPI_SLEEP);
    cmd(8'h03, 8'h00);
    chk_state(state, PNPI_SLEEP);
    cmd(8'h03, 8'h05);
    chk_state(state, PNPI_CONFIG);
    cmd(8'hf6, 8'h04);
    chk_byte(card_select_number, 8'h00);
    chk_state(state, PNPI_CONFIG);
    cmd(8'h02, 8'h02);
    chk_state(state, PNPI_WAIT_KEY);
    $display("t_assign done");
  endtask
  task automatic t_rerun();
    unlock();
    chk_state(state, PNPI_SLEEP);
    cmd(8'h03, 8'h00);
    cmd(8'h06, 8'h07);
    chk_byte(card_select_number, 8'h07);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk_byte(card_select_number, 8'h00);
    chk_state(state, PNPI_WAIT_KEY);
    rst_b <= 1'b1;
    $display("t_rerun done");
  endtask
  initial begin
    logic [7:0] l;
    id_exp[63:0] = {UID, VID};
    l = 8'h6a;
    for (int i = 0; i < 64; i++)
      l = {l[1] ^ l[0] ^ id_exp[i], l[7:1]};
    id_exp[71:64] = l;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    t_idle();
    t_unlock();
    t_pass();
    t_lose();
    t_assign();
    t_rerun();
    end_sim();
  end
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule
